//--- src/spfc_pkg.sv
package spfc_pkg;
  // register map (byte addresses on the avalon word bus)
  localparam logic [3:0] SPFC_OFS_CTRL = 4'h0; // program_memory_control
  localparam logic [3:0] SPFC_OFS_STAT = 4'h4; // block status
  localparam logic [3:0] SPFC_OFS_FUSE = 4'h8; // self-program fuse view
  // control register field positions
  localparam int SPFC_B_EN = 0;
  localparam int SPFC_B_ERS = 1;
  localparam int SPFC_B_WRT = 2;
  localparam int SPFC_B_RFL = 3;
  localparam int SPFC_B_CTB = 4;
  localparam int SPFC_B_SIG = 5;
  localparam logic [7:0] SPFC_CTRL_RST = 8'h00;
  localparam logic [7:0] SPFC_CTRL_MASK = 8'h3f;
  // arm windows in cycles
  localparam logic [2:0] SPFC_STORE_WIN = 3'h4;
  localparam logic [2:0] SPFC_LOAD_WIN = 3'h3;
  // flash operation time, microseconds and clock rate
  localparam int SPFC_T_MIN_US = 3700;
  localparam int SPFC_T_MAX_US = 4500;
  localparam int SPFC_CLK_MHZ = 125;
  localparam int SPFC_OP_CYC = SPFC_T_MIN_US * SPFC_CLK_MHZ;
  // page geometry
  localparam int SPFC_WORD_BITS = 4;
  localparam int SPFC_ADDR_W = 16;

  // sequencer states: idle, busy
  typedef enum logic [1:0] {
    SPFC_OP_IDLE = 2'b00,
    SPFC_OP_BUSY = 2'b01
  } spfc_state_t;

  // cpu instruction request bundle
  typedef struct packed {
    logic store;
    logic load;
    logic [15:0] zptr;
    logic [15:0] src;
  } spfc_instr_t;

  // flash array command bundle
  typedef struct packed {
    logic erase;
    logic write;
    logic [15:0] page_addr;
  } spfc_flash_cmd_t;
endpackage : spfc_pkg

//--- src/spfc_ctrl.sv
// Chosen here: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
// Behaviour
// R1: eeprom busy blocks programming and fuse reads
// R2: software polls eeprom busy before control write
// R3: programmed fuse bits read zero, unprogrammed one
// R4: load within three cycles returns fuse/lock byte
// R5: fuse-read bits self-clear on read or timeout
// R6: with bits clear, load reads flash normally
// R7: lock byte at pointer one, load quickly
// R8: pointer 0,3,2 pick low, high, extended fuse
// R9: pointer bit zero picks lock versus fuse; code gives lock only at pointer one, pointer three reads high fuse
// R10: signature read returns table entry at pointer
// R11: erase/write timed between 3.7 and 4.5 ms
// R12: control bits seven and six read zero
// R13: clear-buffer bit empties temporary buffer
// R14: page write programs buffer into addressed page
// R15: page-write clears on finish/timeout; cpu halted
// R16: page erase erases addressed page
// R17: page-erase clears on finish/timeout; cpu halted
// R18: store-enable permits store for four cycles
// R19: store-enable alone loads buffer word
// R20: store-enable clears after store, holds during operation
// R21: reset does not abort running flash write
// R22: store disabled unless self-program fuse programmed
// R23: buffer erased after write, clear, reset; write-once
// R24: eeprom write during loading loses buffer
// R25: special reads take no extra cpu cycles
module spfc_ctrl
  import spfc_pkg::*;
#(
  parameter int OP_CYC = SPFC_OP_CYC,
  parameter int SIG_N = 8
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // cpu side
  input wire spfc_instr_t cpu_instr,
  output logic cpu_halt,
  output logic [7:0] load_data,
  output logic load_special,
  // flash data and nonvolatile bytes, same clock domain
  input wire logic [7:0] flash_rd_byte,
  input wire logic [7:0] lock_byte,
  input wire logic [7:0] fuse_low,
  input wire logic [7:0] fuse_high,
  input wire logic [7:0] fuse_ext,
  input wire logic [SIG_N*8-1:0] sig_table,
  input wire logic eeprom_write_busy,
  // flash array command
  output spfc_flash_cmd_t flash_cmd,
  output logic [15:0] page_word [1<<SPFC_WORD_BITS],
  output logic por_hold
);
  localparam int NW = 1 << SPFC_WORD_BITS;
  localparam int CW = $clog2(OP_CYC + 1);

  logic [7:0] ctrl_q; // control bits 5:0
  logic [7:0] ctrl_d;
  logic [2:0] win_q; // cycles since arm
  logic [2:0] win_d;
  spfc_state_t st_q;
  spfc_state_t st_d;
  logic [CW-1:0] cnt_q; // operation timer
  logic [CW-1:0] cnt_d;
  logic [NW-1:0] used_q; // write-once marks
  logic [15:0] buf_q [NW];
  logic ee_seen_q; // eeprom write started while loading
  logic [7:0] load_q;
  logic spec_q;
  spfc_flash_cmd_t cmd_q;

  // self-program fuse is bit 0 of the extended fuse, active low
  wire fuse_ok = ~fuse_ext[0]; // see R22
  wire busy = (st_q == SPFC_OP_BUSY);
  wire ctrl_sel = (avs_address == SPFC_OFS_CTRL);
  wire stat_sel = (avs_address == SPFC_OFS_STAT);
  wire fuse_sel = (avs_address == SPFC_OFS_FUSE);
  // writes refused while eeprom busy or an operation runs
  wire ctrl_wr = clk_en & avs_write & ctrl_sel & ~eeprom_write_busy & ~busy; // see R1
  wire armed = ctrl_q[SPFC_B_EN];
  wire in_store = win_q < SPFC_STORE_WIN; // see R18
  wire in_load = win_q < SPFC_LOAD_WIN; // see R4
  wire do_store = clk_en & armed & in_store & cpu_instr.store & fuse_ok & ~busy; // see R22
  wire rfl = armed & ctrl_q[SPFC_B_RFL] & in_load & ~eeprom_write_busy; // see R1
  wire rsg = armed & ctrl_q[SPFC_B_SIG] & in_load;
  wire do_load = clk_en & cpu_instr.load;
  wire is_op = ctrl_q[SPFC_B_ERS] | ctrl_q[SPFC_B_WRT];
  wire plain_load = ~(ctrl_q[SPFC_B_ERS] | ctrl_q[SPFC_B_WRT] | ctrl_q[SPFC_B_RFL]
                     | ctrl_q[SPFC_B_SIG] | ctrl_q[SPFC_B_CTB]);
  wire [SPFC_WORD_BITS-1:0] widx = cpu_instr.zptr[SPFC_WORD_BITS:1]; // see R19
  wire wr_word = do_store & plain_load & ~used_q[widx] & ~ee_seen_q; // see R23
  wire op_start = do_store & is_op;
  wire op_done = busy & (cnt_q == CW'(OP_CYC - 1)); // see R11
  wire buf_clr = (ctrl_wr & avs_writedata[SPFC_B_CTB]) // see R13
               | (op_done & cmd_q.write) | ee_seen_q; // see R23
  wire [7:0] fuse_pick = (cpu_instr.zptr[1:0] == 2'h0) ? fuse_low : // see R8
                         (cpu_instr.zptr[1:0] == 2'h3) ? fuse_high :
                         (cpu_instr.zptr[1:0] == 2'h2) ? fuse_ext : lock_byte;
  // fuse storage already holds programmed bits as zero
  // odd pointer one is the lock byte, pointer three stays the high fuse byte
  wire [7:0] fl_byte = fuse_pick; // see R9 R3
  wire [$clog2(SIG_N)-1:0] sidx = cpu_instr.zptr[$clog2(SIG_N)-1:0];
  wire [7:0] sig_byte = sig_table[sidx*8 +: 8]; // see R10

  // control register next value and self-clearing
  always_comb begin
    ctrl_d = ctrl_q;
    win_d = win_q;
    if (ctrl_wr) begin
      ctrl_d = avs_writedata[7:0] & SPFC_CTRL_MASK; // see R12
      ctrl_d[SPFC_B_CTB] = 1'b0; // clear-buffer acts once
      win_d = 3'h0;
    end else if (busy) begin
      // enable and op bit hold until the operation ends
      if (op_done) begin
        ctrl_d = SPFC_CTRL_RST; // see R15 R17 R20
      end
    end else if (armed) begin
      if (op_start) begin
        win_d = win_q; // hold bits during operation
      end else if (do_store | (do_load & (rfl | rsg))) begin
        ctrl_d = SPFC_CTRL_RST; // see R5 R20
      end else if (~in_store | ((ctrl_q[SPFC_B_RFL] | ctrl_q[SPFC_B_SIG]) & ~in_load)) begin
        ctrl_d = SPFC_CTRL_RST; // see R5 R15 R17 R18
      end else begin
        win_d = win_q + 3'h1;
      end
    end
  end

  // operation sequencer
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    case (st_q)
      SPFC_OP_IDLE: begin
        if (op_start) begin
          st_d = SPFC_OP_BUSY; // see R14 R16
          cnt_d = '0;
        end
      end
      SPFC_OP_BUSY: begin
        if (op_done) begin
          st_d = SPFC_OP_IDLE;
        end else begin
          cnt_d = cnt_q + CW'(1);
        end
      end
      default: st_d = SPFC_OP_IDLE;
    endcase
  end

  // sequencer registers: reset only clears when no operation is running
  // synchronous on purpose, so a running write is never cut short
  always_ff @(posedge mclk) begin
    if (sys_rst && !busy) begin
      st_q <= SPFC_OP_IDLE; // see R21
      cnt_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
    end
  end

  // control register and arm window
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= SPFC_CTRL_RST;
      win_q <= 3'h0;
    end else if (clk_en) begin
      ctrl_q <= ctrl_d;
      win_q <= win_d;
    end
  end

  // flash command latched at start, held through the operation, even across reset
  always_ff @(posedge mclk) begin
    if (sys_rst && !busy) begin
      cmd_q <= '0; // see R21
    end else if (clk_en) begin
      if (op_start) begin
        cmd_q.erase <= ctrl_q[SPFC_B_ERS];
        cmd_q.write <= ctrl_q[SPFC_B_WRT];
        cmd_q.page_addr <= {cpu_instr.zptr[15:SPFC_WORD_BITS+1], {(SPFC_WORD_BITS+1){1'b0}}};
      end else if (op_done) begin
        cmd_q <= '0;
      end
    end
  end

  // temporary page buffer with write-once marks
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      used_q <= '0; // see R23
      ee_seen_q <= 1'b0;
    end else if (clk_en) begin
      ee_seen_q <= eeprom_write_busy & (|used_q) & ~ee_seen_q; // see R24
      if (buf_clr) begin
        used_q <= '0;
      end else if (wr_word) begin
        used_q[widx] <= 1'b1;
      end
    end
  end

  // buffer data: words without a mark read as erased
  for (genvar i = 0; i < NW; i++) begin : g_buf
    always_ff @(posedge mclk) begin
      if (clk_en && wr_word && widx == i) begin
        buf_q[i] <= cpu_instr.src;
      end
    end
    assign page_word[i] = used_q[i] ? buf_q[i] : 16'hffff;
  end

  // load result, same single cycle as a plain read
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      load_q <= 8'h00;
      spec_q <= 1'b0;
    end else if (do_load) begin
      spec_q <= rfl | rsg; // see R25
      if (rfl) begin
        load_q <= fl_byte; // see R4 R7
      end else if (rsg) begin
        load_q <= sig_byte;
      end else begin
        load_q <= flash_rd_byte; // see R6
      end
    end
  end

  assign load_data = load_q;
  assign load_special = spec_q;
  assign flash_cmd = cmd_q;
  assign cpu_halt = busy; // see R15 R17
  // reset hold keeps the array powered while a write finishes
  assign por_hold = busy; // see R21

  // avalon slave, zero wait states
  assign avs_waitrequest = 1'b0;
  always_comb begin
    if (ctrl_sel) begin
      avs_readdata = {24'h00_0000, ctrl_q & SPFC_CTRL_MASK}; // see R12
    end else if (stat_sel) begin
      avs_readdata = {28'h000_0000, ee_seen_q, |used_q, eeprom_write_busy, busy};
    end else if (fuse_sel) begin
      avs_readdata = {31'h0000_0000, fuse_ok};
    end else begin
      avs_readdata = 32'h0000_0000;
    end
  end
endmodule : spfc_ctrl

//--- test/spfc_asserts.sv
`timescale 1ns/1ps
module spfc_asserts
  import spfc_pkg::*;
#(
  parameter int OP_CYC = 20
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire spfc_instr_t cpu_instr,
  input wire logic cpu_halt,
  input wire logic load_special,
  input wire logic [7:0] fuse_ext,
  input wire logic eeprom_write_busy,
  input wire spfc_flash_cmd_t flash_cmd,
  input wire logic [15:0] page_word [16]
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // halt length so far, zero while running
  // kept counting through reset, since an operation survives it
  int hc_q = 0;
  always_ff @(posedge mclk)
    hc_q <= cpu_halt ? hc_q + 1 : 0;
  // a clear-buffer request with enable set; idle_ok checks acceptance
  sequence clr_req;
    avs_write && avs_address == SPFC_OFS_CTRL && avs_writedata[4:0] == 5'h11;
  endsequence
  sequence idle_ok;
    !eeprom_write_busy && !cpu_halt;
  endsequence
  resv_zero_a: assert property (avs_read && avs_address == SPFC_OFS_CTRL
    |-> avs_readdata[31:6] == 0) else $error("reserved bits not zero");
  halt_cmd_a: assert property (cpu_halt |-> flash_cmd.erase || flash_cmd.write)
    else $error("halt without flash command");
  halt_len_a: assert property ($fell(cpu_halt) |-> hc_q == OP_CYC)
    else $error("flash operation length wrong");
  halt_cause_a: assert property ($rose(cpu_halt) |-> $past(cpu_instr.store))
    else $error("operation began without store");
  ee_block_a: assert property (eeprom_write_busy && !cpu_halt |=> !cpu_halt)
    else $error("operation during eeprom write");
  fuse_block_a: assert property (fuse_ext[0] && !cpu_halt |=> !cpu_halt)
    else $error("operation with self-program off");
  load_cause_a: assert property ($rose(load_special) |-> $past(cpu_instr.load))
    else $error("special read without load");
  clr_buf_a: assert property (clr_req ##0 idle_ok |=> page_word[0] == 16'hffff)
    else $error("buffer not cleared");
  wr_clear_a: assert property ($fell(cpu_halt) && $past(flash_cmd.write)
    |-> ##[0:2] page_word[0] == 16'hffff) else $error("buffer kept after write");
endmodule : spfc_asserts

//--- test/spfc_cpu_model.sv
`timescale 1ns/1ps
module spfc_cpu_model
  import spfc_pkg::*;
(
  input wire logic mclk,
  input wire logic cpu_halt,
  output spfc_instr_t cpu_instr
);
  // one instruction pulse; a halted core issues nothing
  task automatic issue(input logic st, input logic [15:0] z, input logic [15:0] s);
    while (cpu_halt) @(posedge mclk);
    cpu_instr <= '{st, !st, z, s};
    @(posedge mclk);
    // released operands flip so stale values never look valid
    cpu_instr <= '{1'b0, 1'b0, ~z, ~s};
  endtask : issue
  initial cpu_instr = '0;
endmodule : spfc_cpu_model

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import spfc_pkg::*;
;
  localparam int OP = 20; // short op time for simulation
  localparam logic [7:0] FL = 8'h5a, LK = 8'hfc, FE = 8'hfe, FH = 8'hdf;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, cpu_halt, load_special;
  logic [7:0] load_data;
  logic [7:0] fuse_ext = FE; // bit0 low: self-program on
  logic ee_busy = 1'b0;
  logic [7:0] fexp [4] = '{FL, LK, FE, FH};
  spfc_instr_t cpu_instr;
  spfc_flash_cmd_t flash_cmd;
  logic [15:0] page_word [16];
  int n_mismatch = 0;
  int cmp_count = 0;
  int n;
  initial forever #4 mclk = ~mclk;
  spfc_cpu_model cpu (.mclk(mclk), .cpu_halt(cpu_halt), .cpu_instr(cpu_instr));
  spfc_ctrl #(.OP_CYC(OP)) uut (.mclk(mclk), .sys_rst(sys_rst), .clk_en(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_instr(cpu_instr), .cpu_halt(cpu_halt),
    .load_data(load_data), .load_special(load_special),
    .flash_rd_byte(~cpu_instr.zptr[7:0]), .lock_byte(LK), .fuse_low(FL),
    .fuse_high(FH), .fuse_ext(fuse_ext), .sig_table(64'h8877_6655_4433_2211),
    .eeprom_write_busy(ee_busy), .flash_cmd(flash_cmd), .page_word(page_word),
    .por_hold());
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %0t %h %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] v;
    @(posedge mclk);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    v = avs_readdata;
    avs_read <= 1'b0;
    chk(v, e);
  endtask : rd
  // load right after arming, result checked once registered
  task automatic ld(input logic [15:0] z, input logic [7:0] e);
    cpu.issue(1'b0, z, 16'h0000);
    repeat (2) @(negedge mclk);
    chk({24'h0, load_data}, {24'h0, e});
  endtask : ld
  // store word then look at buffer slot three
  task automatic st(input logic [15:0] s, input logic [15:0] e);
    cpu.issue(1'b1, 16'h0007, s);
    repeat (2) @(negedge mclk);
    chk({16'h0, page_word[3]}, {16'h0, e});
  endtask : st
  // erase or write, counting halted cycles
  task automatic op(input logic [7:0] c);
    wr(SPFC_OFS_CTRL, {24'h0, c});
    cpu.issue(1'b1, 16'h0020, 16'h0000);
    n = 0;
    @(negedge mclk);
    while (cpu_halt === 1'b1 && n < 1000) begin
      n++;
      @(negedge mclk);
    end
  endtask : op
  task automatic close_out;
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out
  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(SPFC_OFS_CTRL, 32'h0000_0000);
    wr(SPFC_OFS_CTRL, 32'h0000_00c0);
    rd(SPFC_OFS_CTRL, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      wr(SPFC_OFS_CTRL, 32'h0000_0009);
      ld(16'(i), fexp[i]);
      rd(SPFC_OFS_CTRL, 32'h0000_0000);
    end
    ld(16'h0000, 8'hff);
    wr(SPFC_OFS_CTRL, 32'h0000_0021);
    ld(16'h0002, 8'h33);
    wr(SPFC_OFS_CTRL, 32'h0000_0001);
    st(16'h1234, 16'h1234);
    wr(SPFC_OFS_CTRL, 32'h0000_0011);
    @(negedge mclk);
    chk({16'h0, page_word[3]}, 32'h0000_ffff);
    wr(SPFC_OFS_CTRL, 32'h0000_0001);
    repeat (6) @(posedge mclk);
    rd(SPFC_OFS_CTRL, 32'h0000_0000);
    st(16'h5555, 16'hffff);
    wr(SPFC_OFS_CTRL, 32'h0000_0001);
    st(16'hbeef, 16'hbeef);
    @(posedge mclk);
    ee_busy <= 1'b1;
    wr(SPFC_OFS_CTRL, 32'h0000_0009);
    ld(16'h0000, 8'hff);
    chk({16'h0, page_word[3]}, 32'h0000_ffff);
    @(posedge mclk);
    ee_busy <= 1'b0;
    rd(SPFC_OFS_CTRL, 32'h0000_0000);
    wr(SPFC_OFS_CTRL, 32'h0000_0001);
    st(16'h00a5, 16'h00a5);
    op(8'h05);
    chk(n, OP);
    chk({16'h0, page_word[3]}, 32'h0000_ffff);
    rd(SPFC_OFS_CTRL, 32'h0000_0000);
    op(8'h03);
    chk(n, OP);
    rd(SPFC_OFS_CTRL, 32'h0000_0000);
    wr(SPFC_OFS_CTRL, 32'h0000_0005);
    cpu.issue(1'b1, 16'h0020, 16'h0000);
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    @(negedge mclk);
    chk({31'h0, cpu_halt}, 32'h0000_0001);
    while (cpu_halt !== 1'b0) @(posedge mclk);
    rd(SPFC_OFS_CTRL, 32'h0000_0000);
    @(posedge mclk);
    fuse_ext <= 8'hff;
    wr(SPFC_OFS_CTRL, 32'h0000_0001);
    st(16'h0f0f, 16'hffff);
    close_out();
  end
endmodule : tb_top
bind spfc_ctrl spfc_asserts #(.OP_CYC(OP_CYC)) chk_i (.mclk(mclk), .sys_rst(sys_rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .cpu_instr(cpu_instr),
  .cpu_halt(cpu_halt), .load_special(load_special), .fuse_ext(fuse_ext),
  .eeprom_write_busy(eeprom_write_busy), .flash_cmd(flash_cmd), .page_word(page_word));
